// ### lsal_alert.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: flag sets when its channel's comparison reports out of limit
// RULE2: set flag holds until its register is read with cause gone
// RULE3: status one bit 7 reads 1 while any status two flag set
// RULE4: status one bits 6,5,4,2,1: remote two, local, remote one, supplies
// RULE5: status two bits 7 and 6 flag diode two and diode one faults
// RULE6: status two bits 4,3,2 flag fans three, two, one too slow
// RULE7: status two bit 5 flags fan four, or timer over in timer mode
// RULE8: status two bit 1 flags any overtemperature limit exceeded
// RULE9: flags set regardless of mask bits
// RULE10: mask bit 1 only blocks its source from alert; masks at 0x74, 0x75
// RULE11: mask one bits 7,6,5,4,2,0: summary, temps, main, processor supply
// RULE12: alert low while out of limit and until flag register is read
// RULE13: alert can be routed to one of two multifunction pins
// RULE14: host reads return current sticky flag contents
// RULE15: host masks offending source, polls, unmasks once flag clears
// RULE16: mask two bits 7..1 gate diodes, fan four/timer, fans, overtemp
// RULE17: alert disabled after reset until configuration three bit 0 set
// RULE18: alert when unmasked status one flag or unmasked summary set
module lsal_alert
  import lsal_pkg::*;
(
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire lsal_cond_t    cond_i,
  input  wire logic          cmp_valid_i,
  input  wire logic          timer_mode_i,
  input  wire lsal_pin_sel_t pin_sel_i,
  input  wire lsal_req_t     req_i,
  output logic [7:0]         rdata_o,
  output logic               rvalid_o,
  output logic               alert_a_n_o,
  output logic               alert_b_n_o
);

  logic [7:0] status_one_r, status_one_nxt;
  logic [7:0] status_two_r, status_two_nxt;
  logic [7:0] mask_one_r,   mask_one_nxt;
  logic [7:0] mask_two_r,   mask_two_nxt;
  logic [7:0] config_3_r,   config_3_nxt;
  logic [7:0] rdata_r,      rdata_nxt;
  logic       rvalid_r,     rvalid_nxt;
  logic       alert_a_n_r,  alert_a_n_nxt;
  logic       alert_b_n_r,  alert_b_n_nxt;

  logic [7:0] raw_one;
  logic [7:0] raw_two;
  logic       summary;
  logic       alert_req;

  // sticky update: set wins over a read clear, a read only drops bits
  // whose cause is absent
  function automatic logic [7:0] sticky_next(
    input logic [7:0] cur,
    input logic [7:0] raw,
    input logic       valid,
    input logic       rd_hit
  );
    logic [7:0] set_v;
    logic [7:0] keep;
    set_v = valid ? raw : LSAL_ZERO_BYTE;
    keep  = rd_hit ? (cur & raw) : cur;
    return keep | set_v;
  endfunction

  function automatic logic req_hit(
    input lsal_req_t r,
    input logic [7:0] a
  );
    return r.addr == a;
  endfunction

  always_comb begin
    raw_one = LSAL_ZERO_BYTE;
    raw_one[LSAL_S1_REMOTE_TWO] = cond_i.remote_two_temp; // RULE4
    raw_one[LSAL_S1_LOCAL]      = cond_i.local_temp;
    raw_one[LSAL_S1_REMOTE_ONE] = cond_i.remote_one_temp;
    raw_one[LSAL_S1_MAIN_SUP]   = cond_i.main_supply;
    raw_one[LSAL_S1_PROC_SUP]   = cond_i.processor_supply;
    raw_two = LSAL_ZERO_BYTE;
    raw_two[LSAL_S2_DIODE_TWO]  = cond_i.diode_two; // RULE5
    raw_two[LSAL_S2_DIODE_ONE]  = cond_i.diode_one;
    // RULE7
    raw_two[LSAL_S2_FAN_FOUR]   = timer_mode_i ? cond_i.timer_over
                                               : cond_i.fan_four;
    raw_two[LSAL_S2_FAN_THREE]  = cond_i.fan_three; // RULE6
    raw_two[LSAL_S2_FAN_TWO]    = cond_i.fan_two;
    raw_two[LSAL_S2_FAN_ONE]    = cond_i.fan_one;
    raw_two[LSAL_S2_OVERTEMP]   = cond_i.overtemp; // RULE8
  end

  // status flags ignore the masks entirely
  always_comb begin
    status_one_nxt = sticky_next(status_one_r, raw_one, cmp_valid_i,
      req_i.rd && req_hit(req_i, LSAL_ADDR_STATUS_ONE)); // RULE1 RULE2 RULE9
    status_two_nxt = sticky_next(status_two_r, raw_two, cmp_valid_i,
      req_i.rd && req_hit(req_i, LSAL_ADDR_STATUS_TWO)); // RULE1 RULE2 RULE9
  end

  assign summary = |status_two_r; // RULE3

  always_comb begin
    mask_one_nxt = mask_one_r;
    mask_two_nxt = mask_two_r;
    config_3_nxt = config_3_r;
    if (req_i.wr) begin
      unique case (req_i.addr)
        LSAL_ADDR_MASK_ONE: mask_one_nxt = req_i.wdata & LSAL_M1_IMPL;
        LSAL_ADDR_MASK_TWO: mask_two_nxt = req_i.wdata & LSAL_M2_IMPL;
        LSAL_ADDR_CONFIG_3: config_3_nxt = req_i.wdata & LSAL_C3_IMPL;
        default: ;
      endcase
    end
  end

  // reads return the flags as held before this cycle's clear
  always_comb begin
    rvalid_nxt = req_i.rd;
    rdata_nxt  = rdata_r;
    if (req_i.rd) begin
      unique case (req_i.addr)
        LSAL_ADDR_STATUS_ONE: begin
          rdata_nxt = status_one_r & LSAL_S1_IMPL; // RULE14
          rdata_nxt[LSAL_S1_SUMMARY] = summary; // RULE3
        end
        LSAL_ADDR_STATUS_TWO: rdata_nxt = status_two_r & LSAL_S2_IMPL; // RULE14
        LSAL_ADDR_MASK_ONE:   rdata_nxt = mask_one_r;
        LSAL_ADDR_MASK_TWO:   rdata_nxt = mask_two_r;
        LSAL_ADDR_CONFIG_3:   rdata_nxt = config_3_r;
        default:              rdata_nxt = LSAL_ZERO_BYTE;
      endcase
    end
  end

  // second-bank flags pass their own mask and then the summary mask
  always_comb begin
    logic one_hit;
    logic two_hit;
    one_hit =
      (status_one_r[LSAL_S1_REMOTE_TWO] & ~mask_one_r[LSAL_S1_REMOTE_TWO]) |
      (status_one_r[LSAL_S1_LOCAL]      & ~mask_one_r[LSAL_S1_LOCAL]) |
      (status_one_r[LSAL_S1_REMOTE_ONE] & ~mask_one_r[LSAL_S1_REMOTE_ONE]) |
      (status_one_r[LSAL_S1_MAIN_SUP]   & ~mask_one_r[LSAL_S1_MAIN_SUP]) |
      (status_one_r[LSAL_S1_PROC_SUP]   &
       ~mask_one_r[LSAL_M1_PROC_SUP]); // RULE11 RULE10
    two_hit = |(status_two_r & ~mask_two_r & LSAL_S2_IMPL); // RULE16
    alert_req = one_hit |
      (two_hit & ~mask_one_r[LSAL_S1_SUMMARY]); // RULE18 RULE12
  end

  always_comb begin
    alert_a_n_nxt = 1'b1;
    alert_b_n_nxt = 1'b1;
    if (config_3_r[LSAL_CFG3_ALERT_EN] && alert_req) begin // RULE17
      unique case (pin_sel_i) // RULE13
        LSAL_PIN_ALT_A: alert_a_n_nxt = 1'b0;
        LSAL_PIN_ALT_B: alert_b_n_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_one_r <= LSAL_ZERO_BYTE;
      status_two_r <= LSAL_ZERO_BYTE;
      mask_one_r   <= LSAL_ZERO_BYTE;
      mask_two_r   <= LSAL_ZERO_BYTE;
      config_3_r   <= LSAL_ZERO_BYTE;
      rdata_r      <= LSAL_ZERO_BYTE;
      rvalid_r     <= 1'b0;
      alert_a_n_r  <= 1'b1;
      alert_b_n_r  <= 1'b1;
    end else begin
      status_one_r <= status_one_nxt;
      status_two_r <= status_two_nxt;
      mask_one_r   <= mask_one_nxt;
      mask_two_r   <= mask_two_nxt;
      config_3_r   <= config_3_nxt;
      rdata_r      <= rdata_nxt;
      rvalid_r     <= rvalid_nxt;
      alert_a_n_r  <= alert_a_n_nxt;
      alert_b_n_r  <= alert_b_n_nxt;
    end
  end

  assign rdata_o     = rdata_r;
  assign rvalid_o    = rvalid_r;
  assign alert_a_n_o = alert_a_n_r;
  assign alert_b_n_o = alert_b_n_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_flag_sets: assert property ( // RULE1
    cmp_valid_i && cond_i.local_temp |=> status_one_r[LSAL_S1_LOCAL])
    else $error("local flag not set after out-of-limit comparison");

  a_flag_sticky: assert property ( // RULE2
    status_two_r[LSAL_S2_FAN_ONE] &&
    !(req_i.rd && req_i.addr == LSAL_ADDR_STATUS_TWO)
    |=> status_two_r[LSAL_S2_FAN_ONE])
    else $error("fan one flag dropped without a read");

  a_read_clears: assert property ( // RULE2
    req_i.rd && req_i.addr == LSAL_ADDR_STATUS_ONE && !cmp_valid_i &&
    !cond_i.main_supply |=> !status_one_r[LSAL_S1_MAIN_SUP])
    else $error("main supply flag not cleared by read");

  a_summary_read: assert property ( // RULE3
    req_i.rd && req_i.addr == LSAL_ADDR_STATUS_ONE && |status_two_r
    |=> rvalid_o && rdata_o[LSAL_S1_SUMMARY])
    else $error("summary bit not returned");

  a_diode_map: assert property ( // RULE5
    cmp_valid_i && cond_i.diode_two |=> status_two_r[LSAL_S2_DIODE_TWO])
    else $error("diode two flag not set");

  a_timer_mux: assert property ( // RULE7
    cmp_valid_i && timer_mode_i && cond_i.timer_over
    |=> status_two_r[LSAL_S2_FAN_FOUR])
    else $error("timer event not flagged on bit 5");

  a_mask_flags: assert property ( // RULE9
    cmp_valid_i && cond_i.overtemp && mask_two_r[LSAL_S2_OVERTEMP]
    |=> status_two_r[LSAL_S2_OVERTEMP])
    else $error("masked source did not set its flag");

  a_alert_off: assert property ( // RULE17
    !config_3_r[LSAL_CFG3_ALERT_EN] |=> alert_a_n_o && alert_b_n_o)
    else $error("alert asserted while disabled");

  a_alert_drive: assert property ( // RULE12
    config_3_r[LSAL_CFG3_ALERT_EN] && pin_sel_i == LSAL_PIN_ALT_A &&
    status_one_r[LSAL_S1_LOCAL] && !mask_one_r[LSAL_S1_LOCAL]
    |=> !alert_a_n_o)
    else $error("alert not driven for unmasked flag");

  a_summary_mask: assert property ( // RULE18
    status_one_r == LSAL_ZERO_BYTE && mask_one_r[LSAL_S1_SUMMARY]
    |=> alert_a_n_o && alert_b_n_o)
    else $error("second bank reached alert through summary mask");

  // local flag walk: strobe, flag one edge later, pin one edge after that
  sequence s_local_out;
    cmp_valid_i && cond_i.local_temp;
  endsequence

  sequence s_pin_a_armed;
    config_3_r[LSAL_CFG3_ALERT_EN] && !mask_one_r[LSAL_S1_LOCAL] &&
    pin_sel_i == LSAL_PIN_ALT_A;
  endsequence

  a_flag_to_pin: assert property ( // RULE12
    s_local_out ##1 s_pin_a_armed |=> !alert_a_n_o)
    else $error("out-of-limit strobe did not reach the alert pin");

  a_rvalid_pulse: assert property ( // RULE14
    req_i.rd |=> rvalid_o)
    else $error("read not answered one cycle later");

  a_no_stray_valid: assert property ( // RULE14
    !req_i.rd |=> !rvalid_o)
    else $error("read valid without a read");

  a_status_two_data: assert property ( // RULE14
    req_i.rd && req_i.addr == LSAL_ADDR_STATUS_TWO
    |=> rdata_o == $past(status_two_r))
    else $error("status two read data wrong");

  a_summary_live: assert property ( // RULE3
    req_i.rd && req_i.addr == LSAL_ADDR_STATUS_ONE &&
    status_two_r == LSAL_ZERO_BYTE |=> !rdata_o[LSAL_S1_SUMMARY])
    else $error("summary bit set with status two empty");

  a_status_ro: assert property ( // RULE2
    req_i.wr && !req_i.rd && !cmp_valid_i &&
    req_i.addr == LSAL_ADDR_STATUS_ONE
    |=> status_one_r == $past(status_one_r))
    else $error("write changed status one");

  a_mask_one_wr: assert property ( // RULE10 RULE11
    req_i.wr && req_i.addr == LSAL_ADDR_MASK_ONE
    |=> mask_one_r == ($past(req_i.wdata) & LSAL_M1_IMPL))
    else $error("mask one write not held");

  a_mask_two_wr: assert property ( // RULE16
    req_i.wr && req_i.addr == LSAL_ADDR_MASK_TWO
    |=> mask_two_r == ($past(req_i.wdata) & LSAL_M2_IMPL))
    else $error("mask two write not held");

  a_enable_wr: assert property ( // RULE17
    req_i.wr && req_i.addr == LSAL_ADDR_CONFIG_3
    |=> config_3_r[LSAL_CFG3_ALERT_EN] ==
        $past(req_i.wdata[LSAL_CFG3_ALERT_EN]))
    else $error("alert enable write not held");

  a_fan_map: assert property ( // RULE6
    cmp_valid_i && cond_i.fan_three |=> status_two_r[LSAL_S2_FAN_THREE])
    else $error("fan three flag not set");

  a_overtemp_map: assert property ( // RULE8
    cmp_valid_i && cond_i.overtemp |=> status_two_r[LSAL_S2_OVERTEMP])
    else $error("overtemperature flag not set");

  a_pin_b_idle: assert property ( // RULE13
    pin_sel_i == LSAL_PIN_ALT_A |=> alert_b_n_o)
    else $error("unselected pin b driven");

  a_proc_gate: assert property ( // RULE11
    config_3_r[LSAL_CFG3_ALERT_EN] && pin_sel_i == LSAL_PIN_ALT_B &&
    status_one_r[LSAL_S1_PROC_SUP] && !mask_one_r[LSAL_M1_PROC_SUP]
    |=> !alert_b_n_o)
    else $error("processor supply did not use mask bit 0");

endmodule

// ### lsal_host.sv
`timescale 1ns/1ps
// host on the register side: one request per call, then the
// bus is released with scrambled fields so stale values never match
module lsal_host
  import lsal_pkg::*;
(
  input  wire logic clock_i,
  output lsal_req_t req_o
);
  initial req_o = '0;
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clock_i);
    req_o <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clock_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ### lsal_pkg.sv
package lsal_pkg;

  localparam logic [7:0] LSAL_ADDR_STATUS_ONE = 8'h41;
  localparam logic [7:0] LSAL_ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] LSAL_ADDR_MASK_ONE   = 8'h74;
  localparam logic [7:0] LSAL_ADDR_MASK_TWO   = 8'h75;
  localparam logic [7:0] LSAL_ADDR_CONFIG_3   = 8'h78;

  // status one bit positions
  localparam int LSAL_S1_SUMMARY    = 7;
  localparam int LSAL_S1_REMOTE_TWO = 6;
  localparam int LSAL_S1_LOCAL      = 5;
  localparam int LSAL_S1_REMOTE_ONE = 4;
  localparam int LSAL_S1_MAIN_SUP   = 2;
  localparam int LSAL_S1_PROC_SUP   = 1;
  // mask one puts the processor supply at bit 0
  localparam int LSAL_M1_PROC_SUP   = 0;

  // status two / mask two bit positions
  localparam int LSAL_S2_DIODE_TWO  = 7;
  localparam int LSAL_S2_DIODE_ONE  = 6;
  localparam int LSAL_S2_FAN_FOUR   = 5;
  localparam int LSAL_S2_FAN_THREE  = 4;
  localparam int LSAL_S2_FAN_TWO    = 3;
  localparam int LSAL_S2_FAN_ONE    = 2;
  localparam int LSAL_S2_OVERTEMP   = 1;

  localparam int LSAL_CFG3_ALERT_EN = 0;

  localparam logic [7:0] LSAL_ZERO_BYTE = 8'h00;
  // bits that exist in each register
  localparam logic [7:0] LSAL_S1_IMPL = 8'h76;
  localparam logic [7:0] LSAL_S2_IMPL = 8'hFE;
  localparam logic [7:0] LSAL_M1_IMPL = 8'hF5;
  localparam logic [7:0] LSAL_M2_IMPL = 8'hFE;
  localparam logic [7:0] LSAL_C3_IMPL = 8'h01;

  // one condition line per source, from the comparators upstream
  typedef struct packed {
    logic remote_two_temp;
    logic local_temp;
    logic remote_one_temp;
    logic main_supply;
    logic processor_supply;
    logic diode_two;
    logic diode_one;
    logic fan_four;
    logic timer_over;
    logic fan_three;
    logic fan_two;
    logic fan_one;
    logic overtemp;
  } lsal_cond_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsal_req_t;

  typedef enum logic {
    LSAL_PIN_ALT_A,
    LSAL_PIN_ALT_B
  } lsal_pin_sel_t;

endpackage

// ### testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; \
  if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module testbench;
  import lsal_pkg::*;
  logic          clock_i      = 1'b0;
  logic          rst_i        = 1'b1;
  lsal_cond_t    cond_i       = '0;
  logic          cmp_valid_i  = 1'b0;
  logic          timer_mode_i = 1'b0;
  lsal_pin_sel_t pin_sel_i    = LSAL_PIN_ALT_A;
  lsal_req_t     req_i;
  logic [7:0]    rdata_o;
  logic          rvalid_o;
  logic          alert_a_n_o;
  logic          alert_b_n_o;
  int            n_mismatch   = 0;
  int            cmp_count    = 0;
  logic [7:0]    exp_q[$];
  logic [7:0]    mon_e;
  logic [31:0]   seed         = 32'h0000_be6e;

  always #5 clock_i = ~clock_i;

  lsal_alert DUT (.clock_i(clock_i), .rst_i(rst_i), .cond_i(cond_i),
    .cmp_valid_i(cmp_valid_i), .timer_mode_i(timer_mode_i),
    .pin_sel_i(pin_sel_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .alert_a_n_o(alert_a_n_o),
    .alert_b_n_o(alert_b_n_o));
  lsal_host u_host (.clock_i(clock_i), .req_o(req_i));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.access(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d);
  endtask

  // the unselected pin must stay released
  task automatic chk_alert(input logic lo);
    `CHK("alert_a", (pin_sel_i == LSAL_PIN_ALT_A) ? !lo : 1'b1, alert_a_n_o)
    `CHK("alert_b", (pin_sel_i == LSAL_PIN_ALT_B) ? !lo : 1'b1, alert_b_n_o)
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(negedge clock_i) begin
    if (rvalid_o === 1'b1) begin
      mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata_o;
      `CHK("rdata", mon_e, rdata_o)
    end
  end

  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end

  initial begin
    lsal_cond_t cv;
    logic [7:0] m1, m2, s1, s2;
    logic       tm, lo;
    repeat (20) @(posedge clock_i);
    @(negedge clock_i) rst_i = 1'b0;
    wr(LSAL_ADDR_STATUS_ONE, 8'hFF);
    rd(LSAL_ADDR_STATUS_ONE, 8'h00);
    rd(LSAL_ADDR_STATUS_TWO, 8'h00);
    rd(LSAL_ADDR_MASK_ONE, 8'h00);
    rd(LSAL_ADDR_MASK_TWO, 8'h00);
    rd(LSAL_ADDR_CONFIG_3, 8'h00);
    rd(8'h10, 8'h00);
    // all sources out while the alert is still disabled
    @(negedge clock_i) cond_i = '1;
    cmp_valid_i = 1'b1;
    @(negedge clock_i) cmp_valid_i = 1'b0;
    cond_i = '0;
    repeat (2) @(negedge clock_i);
    chk_alert(1'b0);
    rd(LSAL_ADDR_STATUS_ONE, 8'hF6);
    rd(LSAL_ADDR_STATUS_TWO, 8'hFE);
    rd(LSAL_ADDR_STATUS_ONE, 8'h00);
    rd(LSAL_ADDR_STATUS_TWO, 8'h00);
    wr(LSAL_ADDR_CONFIG_3, 8'hFF);
    rd(LSAL_ADDR_CONFIG_3, 8'h01);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      m1 = seed[7:0] & {8{seed[31]}};
      m2 = seed[15:8] & {8{seed[31]}};
      tm = seed[16];
      cv = seed[30:18];
      s2 = {cv.diode_two, cv.diode_one, tm ? cv.timer_over : cv.fan_four,
            cv.fan_three, cv.fan_two, cv.fan_one, cv.overtemp, 1'b0};
      s1 = {|s2, cv.remote_two_temp, cv.local_temp, cv.remote_one_temp,
            1'b0, cv.main_supply, cv.processor_supply, 1'b0};
      lo = |(s1[6:1] & ~{m1[6:2], m1[0]}) | (!m1[7] && |(s2 & ~m2));
      wr(LSAL_ADDR_MASK_ONE, m1);
      wr(LSAL_ADDR_MASK_TWO, m2);
      rd(LSAL_ADDR_MASK_ONE, m1 & LSAL_M1_IMPL);
      rd(LSAL_ADDR_MASK_TWO, m2 & LSAL_M2_IMPL);
      @(negedge clock_i) timer_mode_i = tm;
      pin_sel_i = lsal_pin_sel_t'(seed[17]);
      cond_i = cv;
      cmp_valid_i = 1'b1;
      @(negedge clock_i) cmp_valid_i = 1'b0;
      repeat (2) @(negedge clock_i);
      chk_alert(lo);
      // cause still present: reads must not clear anything
      rd(LSAL_ADDR_STATUS_ONE, s1);
      rd(LSAL_ADDR_STATUS_TWO, s2);
      rd(LSAL_ADDR_STATUS_ONE, s1);
      rd(LSAL_ADDR_STATUS_TWO, s2);
      @(negedge clock_i) cond_i = '0;
      repeat (3) @(negedge clock_i);
      chk_alert(lo);
      rd(LSAL_ADDR_STATUS_ONE, s1);
      rd(LSAL_ADDR_STATUS_ONE, {s1[7], 7'h00});
      rd(LSAL_ADDR_STATUS_TWO, s2);
      rd(LSAL_ADDR_STATUS_TWO, 8'h00);
      rd(LSAL_ADDR_STATUS_ONE, 8'h00);
      repeat (2) @(negedge clock_i);
      chk_alert(1'b0);
    end
    // host recipe: mask the offender, poll until its flag drops, unmask
    wr(LSAL_ADDR_MASK_ONE, 8'h00);
    wr(LSAL_ADDR_MASK_TWO, 8'h00);
    @(negedge clock_i) pin_sel_i = LSAL_PIN_ALT_B;
    cond_i.fan_two = 1'b1;
    cmp_valid_i = 1'b1;
    @(negedge clock_i) cmp_valid_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk_alert(1'b1);
    rd(LSAL_ADDR_STATUS_TWO, 8'h08);
    wr(LSAL_ADDR_MASK_TWO, 8'h08);
    repeat (2) @(negedge clock_i);
    chk_alert(1'b0);
    rd(LSAL_ADDR_STATUS_ONE, 8'h80);
    @(negedge clock_i) cond_i = '0;
    rd(LSAL_ADDR_STATUS_TWO, 8'h08);
    rd(LSAL_ADDR_STATUS_TWO, 8'h00);
    wr(LSAL_ADDR_MASK_TWO, 8'h00);
    repeat (2) @(negedge clock_i);
    chk_alert(1'b0);
    // reset in mid-run drops flags, masks and the enable at once
    @(negedge clock_i) cond_i.local_temp = 1'b1;
    cmp_valid_i = 1'b1;
    @(negedge clock_i) cmp_valid_i = 1'b0;
    cond_i = '0;
    repeat (2) @(negedge clock_i);
    chk_alert(1'b1);
    rst_i = 1'b1;
    @(negedge clock_i) chk_alert(1'b0);
    rst_i = 1'b0;
    rd(LSAL_ADDR_CONFIG_3, 8'h00);
    rd(LSAL_ADDR_STATUS_ONE, 8'h00);
    rd(LSAL_ADDR_MASK_TWO, 8'h00);
    repeat (4) @(negedge clock_i);
    `CHK("pending", 0, exp_q.size())
    close_out();
  end
endmodule
